// file: common/atatf_pkg.sv
/*
  Constants shared by the ATA task file block: register addresses,
  field positions, reset values, geometry and buffer sizes.
  Assumes a single-clock design that imports this package whole.
*/
package atatf_pkg;

  // ----------------------------------------------------------------
  // Register addresses within each select block
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA    = 3'h0;
  localparam logic [2:0] ADDR_ERROR   = 3'h1;
  localparam logic [2:0] ADDR_SECCNT  = 3'h2;
  localparam logic [2:0] ADDR_SECNUM  = 3'h3;
  localparam logic [2:0] ADDR_CYLLO   = 3'h4;
  localparam logic [2:0] ADDR_CYLHI   = 3'h5;
  localparam logic [2:0] ADDR_DRVHEAD = 3'h6;
  localparam logic [2:0] ADDR_STATUS  = 3'h7;
  localparam logic [2:0] ADDR_ALTSTAT = 3'h6;
  localparam logic [2:0] ADDR_DRVADDR = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DH_LBA_BIT   = 6;
  localparam int DH_UNIT_BIT  = 4;
  localparam int DC_IEN_BIT   = 1;
  localparam int DC_SOFT_RESET_BIT  = 2;

  // Error bits that can ever be reported: uncorrectable, ID missing, aborted
  localparam logic [7:0] ERR_SUPPORTED = 8'h54;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SECCNT_RESET  = 8'h01;
  localparam logic [7:0] DH_FIXED_ONES = 8'hA0;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // ----------------------------------------------------------------
  // Bus lane enables and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] OE_WORD    = 16'hFFFF;
  localparam logic [15:0] OE_BYTE    = 16'h00FF;
  localparam logic [15:0] OE_DRVADDR = 16'h007F;
  localparam logic [8:0]  COUNT_FULL = 9'h100;

  // ----------------------------------------------------------------
  // Logical geometry and buffering
  // ----------------------------------------------------------------
  localparam int GEO_HEADS   = 16;
  localparam int GEO_SPT     = 63;
  localparam int DATA_WIDTH  = 16;
  localparam int FIFO_DEPTH  = 8;

endpackage

// file: rtl/atatf_regs.sv
/*
  ATA task file register block with its data buffers.
  Holds the word FIFO and the top module atatf_regs.
  Assumes host pins already synchronous to MCLK, a command engine on
  the user side, and bus wire resolution done outside from the enables.
*/
// Notes on behaviour
// - Decode two selects and three address bits
// - Control block: 6 alt status/control, 7 address
// - Data port is 16 bits, buffer to host
// - Error layout fixed; media change bits read 0
// - Sector count zero means 256 sectors
// - Completion leaves remaining sectors in count
// - Sector count starts at 01H
// - Sector number updated at command completion
// - Cylinder registers updated at command completion
// - Drive/head bits 7,5 read one
// - Status byte layout with index bit zero
// - Busy locks out command and buffer access
// - Status read clears pending interrupt
// - Alternate status read leaves interrupt alone
// - Ready cleared at reset, frozen after error
// - Interrupt pin driven only enabled and selected
// - Control bit 2 performs soft reset
// - Drive address: inverted head and unit lines
// - Linear LBA from cylinder, head, sector
// - Addressing mode taken per command
// - Word indication low on data transfers
`timescale 1ns/1ps

module atatf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,        // System clock
  input  wire logic             rst,        // Synchronous reset
  input  wire logic             in_valid,   // Push request
  output logic                  in_ready,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data,    // Pushed word
  output logic                  out_valid,  // Word available
  input  wire logic             out_ready,  // Pop request
  output logic [WIDTH-1:0]      out_data    // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem_q[rp_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Flags registered so ready and valid never depend on the far side
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q     <= '0;
      wp_q      <= '0;
      rp_q      <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != (AW+1)'(DEPTH));
      out_valid <= (cnt_d != '0);
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule

module atatf_regs
  import atatf_pkg::*;
(
  input  wire logic        MCLK,             // 40 MHz clock
  input  wire logic        RST,              // Synchronous reset, high
  input  wire logic        UNIT_IS_SLAVE,    // Strap: this unit answers to unit 1
  input  wire logic        CMD_BLOCK_SEL_N,  // Command block select
  input  wire logic        CTRL_BLOCK_SEL_N, // Control block select
  input  wire logic        REG_ADDR2,        // Register address bit 2
  input  wire logic        REG_ADDR1,        // Register address bit 1
  input  wire logic        REG_ADDR0,        // Register address bit 0
  input  wire logic        RD_STROBE_N,      // Host read strobe
  input  wire logic        WR_STROBE_N,      // Host write strobe
  input  wire logic [15:0] DATA_IN,          // Host data bus, in
  output logic      [15:0] DATA_OUT,         // Host data bus, out
  output logic      [15:0] DATA_OE,          // Per-bit drive enable
  output logic             WORD_CYCLE_N_O,   // Open-drain level, always low
  output logic             WORD_CYCLE_N_OE,  // Pulls word indication low
  output logic             HOST_IRQ_O,       // Interrupt level
  output logic             HOST_IRQ_OE,      // Interrupt pin driven
  output logic             SOFT_RESET,       // Soft reset held to engine
  output logic             CMD_START,        // One-cycle command start
  output logic      [7:0]  CMD_CODE,         // Command byte
  output logic      [7:0]  CMD_FEATURE,      // Feature byte
  output logic      [8:0]  CMD_COUNT,        // Sectors, 1 to 256
  output logic      [27:0] CMD_LBA,          // Linear start address
  output logic             CMD_LBA_MODE,     // Command used LBA addressing
  input  wire logic        ENG_READY,        // Engine can take a command
  input  wire logic        ENG_SEEK_DONE,    // Sector found
  input  wire logic        ENG_WRITE_FAULT,  // Write fault seen
  input  wire logic        ENG_CORRECTED,    // Data corrected
  input  wire logic        XFER_ACTIVE,      // Data phase open
  input  wire logic        XFER_TO_HOST,     // Data phase direction
  input  wire logic        DONE,             // One-cycle completion
  input  wire logic        DONE_ERR,         // Completion with error
  input  wire logic [7:0]  DONE_ERR_BITS,    // Error cause
  input  wire logic [7:0]  DONE_COUNT,       // Sectors left
  input  wire logic [7:0]  DONE_SECTOR,      // Final sector / LBA 7:0
  input  wire logic [15:0] DONE_CYL,         // Final cylinder / LBA 23:8
  input  wire logic [3:0]  DONE_HEAD,        // Final head / LBA 27:24
  output logic      [15:0] WRF_DATA,         // Host write words to engine
  output logic             WRF_VALID,        // Write word available
  input  wire logic        WRF_READY,        // Engine takes write word
  input  wire logic [15:0] RDF_DATA,         // Engine read words
  input  wire logic        RDF_VALID,        // Read word offered
  output logic             RDF_READY         // Room for read word
);
  // ----------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------
  logic [2:0]  addr;
  logic        cmd_sel;
  logic        ctrl_sel;
  logic        rd_n_q;
  logic        wr_n_q;
  logic        rd_end;
  logic        wr_end;
  logic        slave_q;
  logic        unit_sel;
  logic        busy_q;
  logic [7:0]  err_q;
  logic [7:0]  feat_q;
  logic [7:0]  sc_q;
  logic [7:0]  sn_q;
  logic [7:0]  cl_q;
  logic [7:0]  ch_q;
  logic [7:0]  dh_q;
  logic        ien_n_q;
  logic        soft_reset_q;
  logic        irq_q;
  logic        ready_q;
  logic        err_hold_q;
  logic        errflag_q;
  logic        drq_q;
  logic [7:0]  status;
  logic [7:0]  drvaddr;
  logic [15:0] rd_val;
  logic [15:0] rd_oe;
  logic        word_acc;
  logic        wr_data;
  logic        wr_cmd;
  logic        rd_data;
  logic        rd_status;
  logic        rd_alt;
  logic        wrf_in_ready;
  logic        rdf_out_valid;
  logic [15:0] rdf_head;
  logic [27:0] chs_lba;

  assign addr     = {REG_ADDR2, REG_ADDR1, REG_ADDR0};
  assign cmd_sel  = !CMD_BLOCK_SEL_N && CTRL_BLOCK_SEL_N;
  assign ctrl_sel = CMD_BLOCK_SEL_N && !CTRL_BLOCK_SEL_N;
  assign unit_sel = (dh_q[DH_UNIT_BIT] == slave_q);
  // Accesses act on the trailing edge of each strobe
  assign rd_end   = !rd_n_q && RD_STROBE_N;
  assign wr_end   = !wr_n_q && WR_STROBE_N;

  assign wr_data   = wr_end && cmd_sel && unit_sel && !busy_q && addr == ADDR_DATA;
  assign wr_cmd    = wr_end && cmd_sel && unit_sel && !busy_q && addr == ADDR_STATUS;
  assign rd_data   = rd_end && cmd_sel && unit_sel && !busy_q && addr == ADDR_DATA;
  assign rd_status = rd_end && cmd_sel && unit_sel && addr == ADDR_STATUS;
  assign rd_alt    = rd_end && ctrl_sel && unit_sel && addr == ADDR_ALTSTAT;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      slave_q <= 1'b0;
    end else begin
      rd_n_q  <= RD_STROBE_N;
      wr_n_q  <= WR_STROBE_N;
    end
    // Strap follows the pin during reset and is held afterwards
    if (RST) begin
      slave_q <= UNIT_IS_SLAVE;
    end
  end

  // ----------------------------------------------------------------
  // Task file registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST || soft_reset_q) begin
      sc_q   <= SECCNT_RESET;
      sn_q   <= BYTE_ZERO;
      cl_q   <= BYTE_ZERO;
      ch_q   <= BYTE_ZERO;
      feat_q <= BYTE_ZERO;
      err_q  <= BYTE_ZERO;
      dh_q   <= DH_FIXED_ONES;
    end else if (DONE) begin
      sc_q  <= DONE_COUNT;
      sn_q  <= DONE_SECTOR;
      cl_q  <= DONE_CYL[7:0];
      ch_q  <= DONE_CYL[15:8];
      dh_q  <= {dh_q[7:4], DONE_HEAD};
      err_q <= DONE_ERR ? (DONE_ERR_BITS & ERR_SUPPORTED) : BYTE_ZERO;
    end else if (wr_end && cmd_sel && !busy_q) begin
      // Both units latch task file writes, as on a shared cable
      case (addr)
        ADDR_ERROR: begin
          feat_q <= DATA_IN[7:0];
        end
        ADDR_SECCNT: begin
          sc_q <= DATA_IN[7:0];
        end
        ADDR_SECNUM: begin
          sn_q <= DATA_IN[7:0];
        end
        ADDR_CYLLO: begin
          cl_q <= DATA_IN[7:0];
        end
        ADDR_CYLHI: begin
          ch_q <= DATA_IN[7:0];
        end
        ADDR_DRVHEAD: begin
          dh_q <= DATA_IN[7:0] | DH_FIXED_ONES;
        end
        default: begin
        end
      endcase
    end
  end

  // Device control writes are taken even while busy, to end a reset
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ien_n_q <= 1'b0;
      soft_reset_q  <= 1'b0;
    end else if (wr_end && ctrl_sel && addr == ADDR_ALTSTAT) begin
      ien_n_q <= DATA_IN[DC_IEN_BIT];
      soft_reset_q  <= DATA_IN[DC_SOFT_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Status, busy, interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      busy_q <= 1'b0;
    end else if (soft_reset_q || wr_cmd) begin
      busy_q <= 1'b1;
    end else if (DONE || soft_reset_q != 1'b0) begin
      busy_q <= 1'b0;
    end else if (wr_end && ctrl_sel && addr == ADDR_ALTSTAT && !DATA_IN[DC_SOFT_RESET_BIT]) begin
      busy_q <= busy_q;
    end
  end

  // Completion wins over a status read in the same cycle
  always_ff @(posedge MCLK) begin
    if (RST || soft_reset_q) begin
      irq_q <= 1'b0;
    end else if (DONE) begin
      irq_q <= 1'b1;
    end else if (rd_status) begin
      irq_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      ready_q    <= 1'b0;
      err_hold_q <= 1'b0;
      errflag_q  <= 1'b0;
    end else begin
      if (DONE) begin
        err_hold_q <= DONE_ERR;
        errflag_q  <= DONE_ERR;
      end else if (rd_status) begin
        err_hold_q <= 1'b0;
      end
      if (wr_cmd || soft_reset_q) begin
        errflag_q <= 1'b0;
      end
      if (!err_hold_q) begin
        ready_q <= ENG_READY;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      drq_q <= 1'b0;
    end else begin
      drq_q <= XFER_ACTIVE && (XFER_TO_HOST ? rdf_out_valid : wrf_in_ready);
    end
  end

  assign status  = {busy_q, ready_q, ENG_WRITE_FAULT, ENG_SEEK_DONE,
                    drq_q, ENG_CORRECTED, 1'b0, errflag_q};
  assign drvaddr = {1'b0, 1'b1, ~dh_q[3:0],
                    ~dh_q[DH_UNIT_BIT], dh_q[DH_UNIT_BIT]};

  // ----------------------------------------------------------------
  // Read multiplexer and pin drivers
  // ----------------------------------------------------------------
  always_comb begin
    rd_val   = '0;
    rd_oe    = '0;
    word_acc = 1'b0;
    if (cmd_sel && unit_sel) begin
      rd_oe = OE_BYTE;
      case (addr)
        ADDR_DATA: begin
          rd_val   = rdf_head;
          rd_oe    = OE_WORD;
          word_acc = 1'b1;
        end
        ADDR_ERROR: begin
          rd_val = {BYTE_ZERO, err_q};
        end
        ADDR_SECCNT: begin
          rd_val = {BYTE_ZERO, sc_q};
        end
        ADDR_SECNUM: begin
          rd_val = {BYTE_ZERO, sn_q};
        end
        ADDR_CYLLO: begin
          rd_val = {BYTE_ZERO, cl_q};
        end
        ADDR_CYLHI: begin
          rd_val = {BYTE_ZERO, ch_q};
        end
        ADDR_DRVHEAD: begin
          rd_val = {BYTE_ZERO, dh_q | DH_FIXED_ONES};
        end
        default: begin
          rd_val = {BYTE_ZERO, status};
        end
      endcase
    end else if (ctrl_sel && unit_sel && addr == ADDR_ALTSTAT) begin
      rd_val = {BYTE_ZERO, status};
      rd_oe  = OE_BYTE;
    end else if (ctrl_sel && unit_sel && addr == ADDR_DRVADDR) begin
      rd_val = {BYTE_ZERO, drvaddr};
      rd_oe  = OE_DRVADDR;                                   // Top bit stays undriven
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      DATA_OUT        <= '0;
      DATA_OE         <= '0;
      WORD_CYCLE_N_O  <= 1'b0;
      WORD_CYCLE_N_OE <= 1'b0;
    end else begin
      DATA_OUT        <= RD_STROBE_N ? '0 : rd_val;
      DATA_OE         <= RD_STROBE_N ? '0 : rd_oe;
      WORD_CYCLE_N_OE <= word_acc;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      HOST_IRQ_O  <= 1'b0;
      HOST_IRQ_OE <= 1'b0;
      SOFT_RESET  <= 1'b0;
    end else begin
      HOST_IRQ_O  <= irq_q;
      HOST_IRQ_OE <= !ien_n_q && unit_sel;
      SOFT_RESET  <= soft_reset_q;
    end
  end

  // ----------------------------------------------------------------
  // Command launch
  // ----------------------------------------------------------------
  // Linear mapping kept to one multiply chain; fixed geometry only
  assign chs_lba = 28'((20'({ch_q, cl_q}) * 20'(GEO_HEADS) + 20'(dh_q[3:0])) * 28'(GEO_SPT))
                 + 28'(sn_q) - 28'(1);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      CMD_START    <= 1'b0;
      CMD_CODE     <= '0;
      CMD_FEATURE  <= '0;
      CMD_COUNT    <= '0;
      CMD_LBA      <= '0;
      CMD_LBA_MODE <= 1'b0;
    end else begin
      CMD_START <= wr_cmd;
      if (wr_cmd) begin
        CMD_CODE     <= DATA_IN[7:0];
        CMD_FEATURE  <= feat_q;
        CMD_COUNT    <= (sc_q == BYTE_ZERO) ? COUNT_FULL : {1'b0, sc_q};
        CMD_LBA_MODE <= dh_q[DH_LBA_BIT];
        CMD_LBA      <= dh_q[DH_LBA_BIT] ? {dh_q[3:0], ch_q, cl_q, sn_q} : chs_lba;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data buffers
  // ----------------------------------------------------------------
  atatf_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(FIFO_DEPTH)) u_wrf (
    .clk       (MCLK),
    .rst       (RST),
    .in_valid  (wr_data),
    .in_ready  (wrf_in_ready),
    .in_data   (DATA_IN),
    .out_valid (WRF_VALID),
    .out_ready (WRF_READY),
    .out_data  (WRF_DATA)
  );

  atatf_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(FIFO_DEPTH)) u_rdf (
    .clk       (MCLK),
    .rst       (RST),
    .in_valid  (RDF_VALID),
    .in_ready  (RDF_READY),
    .in_data   (RDF_DATA),
    .out_valid (rdf_out_valid),
    .out_ready (rd_data),
    .out_data  (rdf_head)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cmd_sets_busy: assert property (@(posedge MCLK) disable iff (RST)
    wr_cmd && !soft_reset_q |=> busy_q && CMD_START ##1 !CMD_START) else $error("command write did not set busy");
  chk_zero_count: assert property (@(posedge MCLK) disable iff (RST)
    wr_cmd && sc_q == BYTE_ZERO |=> CMD_COUNT == COUNT_FULL) else $error("zero count not 256");
  chk_status_clears: assert property (@(posedge MCLK) disable iff (RST)
    rd_status && !DONE |=> ##1 !HOST_IRQ_O) else $error("status read left interrupt");
  chk_alt_keeps_irq: assert property (@(posedge MCLK) disable iff (RST)
    rd_alt && irq_q && !soft_reset_q |=> irq_q) else $error("alternate status cleared interrupt");
  chk_irq_pin_off: assert property (@(posedge MCLK) disable iff (RST)
    ien_n_q || !unit_sel |=> !HOST_IRQ_OE) else $error("interrupt driven while disabled");
  chk_ready_frozen: assert property (@(posedge MCLK) disable iff (RST)
    err_hold_q && !DONE |=> $stable(ready_q)) else $error("ready changed before status read");
  chk_done_update: assert property (@(posedge MCLK) disable iff (RST)
    DONE && !soft_reset_q |=> sc_q == $past(DONE_COUNT) && sn_q == $past(DONE_SECTOR)) else $error("completion not stored");
  chk_dh_ones: assert property (@(posedge MCLK) disable iff (RST)
    !RD_STROBE_N && cmd_sel && unit_sel && addr == ADDR_DRVHEAD |=> DATA_OUT[7] && DATA_OUT[5])
    else $error("drive head fixed bits low");
  chk_word_flag: assert property (@(posedge MCLK) disable iff (RST)
    cmd_sel && unit_sel && addr == ADDR_DATA |=> WORD_CYCLE_N_OE) else $error("word indication missing");
  chk_soft_reset_busy: assert property (@(posedge MCLK) disable iff (RST)
    soft_reset_q |=> busy_q && sc_q == SECCNT_RESET) else $error("soft reset not applied");

  cov_cmd_done: cover property (@(posedge MCLK) disable iff (RST) wr_cmd ##[1:50] DONE);
  cov_data_read: cover property (@(posedge MCLK) disable iff (RST) rd_data && rdf_out_valid);
  cov_wrf_full: cover property (@(posedge MCLK) disable iff (RST) XFER_ACTIVE && !wrf_in_ready);
endmodule

// file: tb/atatf_host_model.sv
/*
  Host bus controller model for the task file block.
  Assumes MCLK from the bench; the bench calls its task by hierarchy.
*/
`timescale 1ns/1ps
module atatf_host_model (
  input  wire logic        MCLK,     // Bench clock
  output logic             CS0_N,    // Command block select
  output logic             CS1_N,    // Control block select
  output logic [2:0]       ADDR,     // Register address
  output logic             RD_N,     // Read strobe
  output logic             WR_N,     // Write strobe
  output logic [15:0]      DQ,       // Write data
  input  wire logic [15:0] DATA_OUT  // Read data
);
  initial begin
    {CS0_N, CS1_N, RD_N, WR_N} = 4'hF;
    ADDR = 3'h0;
    DQ = 16'h0000;
  end
  // Strobe two cycles low, then one high with selects kept
  task automatic acc(input logic c0, input logic [2:0] a, input logic w, input logic [15:0] d,
                     output logic [15:0] q);
    @(negedge MCLK);
    CS0_N = ~c0;
    CS1_N = c0;
    ADDR = a;
    DQ = d;
    RD_N = w;
    WR_N = ~w;
    repeat (2) @(negedge MCLK);
    q = DATA_OUT;
    {RD_N, WR_N} = 2'h3;  // Data held over trailing edge
    @(negedge MCLK);
    {CS0_N, CS1_N} = 2'h3;
    DQ = ~d;  // Released bus shows no stale value
  endtask
endmodule

// file: tb/atatf_regs_tb_top.sv
/*
  Self-checking bench for atatf_regs: host cycles through the model,
  engine side driven here. Assumes unit 0 strap and fixed geometry.
*/
`timescale 1ns/1ps
module atatf_regs_tb_top;
  import atatf_pkg::*;
  logic        MCLK = 1'b0, RST = 1'b1, done = 1'b0, e_err = 1'b1, xfer = 1'b0, wrf_rdy = 1'b0, saw16 = 1'b0;
  logic        cs0_n, cs1_n, rd_n, wr_n, wrf_v, irq_o, irq_oe, soft_reset, lmode, wc_oe;
  logic [2:0]  addr;
  logic [3:0]  flg = 4'hF;
  logic [8:0]  cnt;
  logic [15:0] dq, dout, wrf_d, q;
  logic [27:0] lba;
  logic        xto = 1'b0, rdf_v = 1'b0;
  logic [7:0]  ebits = 8'hFF, code;
  logic [15:0] rdf_d = 16'h0000, oe, oe_rd;
  int          bad_count = 0, checked = 0, n;
  initial forever #12.5 MCLK = ~MCLK;
  atatf_host_model atatf_host_model_i (.MCLK(MCLK), .CS0_N(cs0_n), .CS1_N(cs1_n), .ADDR(addr), .RD_N(rd_n),
    .WR_N(wr_n), .DQ(dq), .DATA_OUT(dout));
  atatf_regs atatf_regs_i (.MCLK(MCLK), .RST(RST), .UNIT_IS_SLAVE(1'b0), .CMD_BLOCK_SEL_N(cs0_n),
    .CTRL_BLOCK_SEL_N(cs1_n), .REG_ADDR2(addr[2]), .REG_ADDR1(addr[1]), .REG_ADDR0(addr[0]), .RD_STROBE_N(rd_n),
    .WR_STROBE_N(wr_n), .DATA_IN(dq), .DATA_OUT(dout), .DATA_OE(oe), .WORD_CYCLE_N_O(), .WORD_CYCLE_N_OE(wc_oe),
    .HOST_IRQ_O(irq_o), .HOST_IRQ_OE(irq_oe), .SOFT_RESET(soft_reset), .CMD_START(), .CMD_CODE(code), .CMD_FEATURE(),
    .CMD_COUNT(cnt), .CMD_LBA(lba), .CMD_LBA_MODE(lmode), .ENG_READY(flg[3]), .ENG_SEEK_DONE(flg[2]),
    .ENG_WRITE_FAULT(flg[1]), .ENG_CORRECTED(flg[0]), .XFER_ACTIVE(xfer), .XFER_TO_HOST(xto), .DONE(done),
    .DONE_ERR(e_err), .DONE_ERR_BITS(ebits), .DONE_COUNT(8'h03), .DONE_SECTOR(8'h09), .DONE_CYL(16'h1234),
    .DONE_HEAD(4'h4), .WRF_DATA(wrf_d), .WRF_VALID(wrf_v), .WRF_READY(wrf_rdy), .RDF_DATA(rdf_d),
    .RDF_VALID(rdf_v), .RDF_READY());
  always @(negedge MCLK) if (!cs0_n && addr == ADDR_DATA && wc_oe) saw16 <= 1'b1;
  // Last lane enable seen while the read strobe is low
  always @(negedge MCLK) if (!rd_n) oe_rd <= oe;
  task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic c0, input logic [2:0] a);
    atatf_host_model_i.acc(c0, a, 1'b0, 16'h0000, q);
    q = q & 16'h00FF;
  endtask
  task automatic wr(input logic c0, input logic [2:0] a, input logic [15:0] d);
    atatf_host_model_i.acc(c0, a, 1'b1, d, q);
  endtask
  // Engine completion: one-cycle pulse, irq visible two cycles on
  task automatic fin;
    @(negedge MCLK) done = 1'b1;
    @(negedge MCLK) done = 1'b0;
    repeat (2) @(negedge MCLK);
  endtask
  task automatic stop_test;
    $display("counts: checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (10) @(negedge MCLK);
    RST = 1'b0;
    rd(1, ADDR_SECCNT); chk(q, 8'h01);
    rd(1, ADDR_DRVHEAD); chk(q, 8'hA0);
    $display("test reset values done");
    wr(1, ADDR_SECCNT, 0); wr(1, ADDR_SECNUM, 5); wr(1, ADDR_CYLLO, 2); wr(1, ADDR_CYLHI, 0);
    wr(1, ADDR_DRVHEAD, 16'h00A3);
    rd(0, ADDR_DRVADDR); chk(q & 16'h007F, 8'h72);
    chk(oe_rd, 16'h007F);
    wr(1, ADDR_STATUS, 16'h0020);
    rd(0, ADDR_ALTSTAT); chk(q[7], 1'b1);
    chk(code, 8'h20);
    chk(cnt, 9'h100);
    chk(lba, 28'h00008A1);
    chk(lmode, 1'b0);
    fin;
    chk(irq_o & irq_oe, 1'b1);
    rd(0, ADDR_ALTSTAT); chk(irq_o, 1'b1);
    rd(1, ADDR_STATUS); chk(q, 8'h75);
    chk(oe_rd, 16'h00FF);
    @(negedge MCLK); chk(irq_o, 1'b0);
    rd(1, ADDR_ERROR); chk(q, 8'h54);
    rd(1, ADDR_SECCNT); chk(q, 8'h03);
    rd(1, ADDR_SECNUM); chk(q, 8'h09);
    rd(1, ADDR_CYLLO); chk(q, 8'h34);
    rd(1, ADDR_CYLHI); chk(q, 8'h12);
    $display("test chs command done");
    wr(1, ADDR_DRVHEAD, 16'h00E1); wr(1, ADDR_SECNUM, 16'h0056); wr(1, ADDR_CYLLO, 16'h0034);
    wr(1, ADDR_CYLHI, 16'h0012); wr(1, ADDR_STATUS, 16'h00C4);
    repeat (2) @(negedge MCLK);
    chk(lba, 28'h1123456);
    chk(lmode, 1'b1);
    e_err = 1'b0;
    fin;
    wr(0, ADDR_ALTSTAT, 16'h0002);
    @(negedge MCLK); chk(irq_oe, 1'b0);
    $display("test lba command done");
    // Nine words into an eight-word buffer: the last is dropped
    xfer = 1'b1;
    for (int i = 0; i < 9; i++) wr(1, ADDR_DATA, 16'hA000 + 16'(i));
    chk(saw16, 1'b1);
    n = 0;
    wrf_rdy = 1'b1;
    // Head word compared before the edge that pops it
    repeat (12) begin
      if (wrf_v === 1'b1) begin
        chk(wrf_d, 16'hA000 + 16'(n));
        n++;
      end
      @(negedge MCLK);
    end
    chk(28'(n), 28'd8);
    $display("test data buffer done");
    xto = 1'b1;
    rdf_d = 16'h5AC3;
    rdf_v = 1'b1;
    @(negedge MCLK);
    rdf_v = 1'b0;
    rd(0, ADDR_ALTSTAT); chk(q[3], 1'b1);
    atatf_host_model_i.acc(1'b1, ADDR_DATA, 1'b0, 16'h0000, q);
    chk(q, 16'h5AC3);
    chk(oe_rd, 16'hFFFF);
    rd(0, ADDR_ALTSTAT); chk(q[3], 1'b0);
    $display("test read buffer done");
    wr(0, ADDR_ALTSTAT, 16'h0004);
    @(negedge MCLK); chk(soft_reset, 1'b1);
    rd(1, ADDR_SECCNT); chk(q, 8'h01);
    wr(0, ADDR_ALTSTAT, 16'h0000);
    fin;
    rd(0, ADDR_ALTSTAT); chk(q[7], 1'b0);
    $display("test soft reset done");
    stop_test;
  end
endmodule
